// ---- shared/thrdp_cfg.svh ----
// register offsets, field positions and reset values of the host register bank
`ifndef THRDP_CFG_SVH
`define THRDP_CFG_SVH
`define THRDP_OFF_BOARD_IDENTIFICATION    9'h000
`define THRDP_OFF_XCVR        9'h004
`define THRDP_OFF_IRQ_SET     9'h008
`define THRDP_OFF_TRG_DLY     9'h00C
`define THRDP_OFF_DMA_POS     9'h010
`define THRDP_OFF_BLK_SIZE    9'h014
`define THRDP_OFF_EVT_FMT     9'h018
`define THRDP_OFF_HOST_SET    9'h01C
`define THRDP_OFF_LUT_BASE    9'h1C0
`define THRDP_RST_CRATE_ID    8'h00
`define THRDP_RST_XCVR_BYP    1'h1
`define THRDP_RST_IRQ_ID      8'hC8
`define THRDP_RST_IRQ_LVL     3'h5
`define THRDP_RST_TRG_FIELD   8'h07
`define THRDP_RST_BLK_SIZE    8'h01
`define THRDP_RST_EVT_FMT     4'h3
`define THRDP_RUN_CODE        2'h2
`define THRDP_I2C_SEL         3'h5
`define THRDP_BIT_BLK_UPD     21
`define THRDP_BIT_BLK_DMA     22
`define THRDP_BIT_IRQ_EN      23
`define THRDP_BIT_ONE_BLK     24
`define THRDP_BIT_AUTO_RST    25
`define THRDP_BIT_DMA_EN      26
`define THRDP_EOF_LIMIT       9'h100
`define THRDP_BLOCK_WORDS     10'h3FF
`endif

// ---- shared/thrdp_pkg.sv ----
// types shared by the host register bank and its helpers
package thrdp_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [1:0]  win;
        logic [19:0] addr;
        logic [31:0] wdata;
    } thrdp_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } thrdp_rsp_t;

    typedef struct packed {
        logic [7:0] crate_id;
        logic       xcvr_byp;
        logic [7:0] irq_id;
        logic [2:0] irq_lvl;
        logic       irq_en;
        logic [7:0] t1_dly;
        logic [7:0] t1_wid;
        logic [7:0] t2_dly;
        logic [7:0] t2_wid;
        logic [7:0] blk_wr;
        logic [3:0] evt_fmt;
        logic       blk_upd;
        logic       blk_dma;
        logic       cpu_irq;
        logic       auto_rst;
        logic       dma_en;
        logic [2:0] w1_sel;
    } thrdp_ctl_t;

    typedef enum logic [1:0] {
        THRDP_IDLE,
        THRDP_SEND
    } thrdp_dma_st_t;
endpackage

// ---- hw/thrdp_trig_shaper.sv ----
// delay and stretch one trigger pulse in 4 ns steps
`timescale 1ns/100ps
module thrdp_trig_shaper (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       trig_in,
    input  wire logic [7:0] delay_n,
    input  wire logic [7:0] width_n,
    output logic            trig_out
);
    typedef struct packed {
        logic       dly_run;
        logic [8:0] dly_cnt;
        logic [8:0] wid_cnt;
        logic       out;
    } thrdp_shp_t;

    thrdp_shp_t s_q;
    thrdp_shp_t s_d;

    // (n+1) clock cycles
    always_comb begin
        s_d = s_q;
        if (trig_in && !s_q.dly_run) begin
            s_d.dly_run = 1'b1;
            s_d.dly_cnt = {1'b0, delay_n};
        end else if (s_q.dly_run) begin
            if (s_q.dly_cnt == 9'h000) begin
                s_d.dly_run = 1'b0;
                s_d.wid_cnt = {1'b0, width_n} + 9'h001;
            end else begin
                s_d.dly_cnt = s_q.dly_cnt - 9'h001;
            end
        end
        if (s_q.wid_cnt != 9'h000 && !(s_q.dly_run && s_q.dly_cnt == 9'h000))
        begin
            s_d.wid_cnt = s_q.wid_cnt - 9'h001;
        end
        s_d.out = (s_d.wid_cnt != 9'h000);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign trig_out = s_q.out;
endmodule

// ---- hw/thrdp_trig_lut.sv ----
// six-input trigger type lookup table, written in 32-bit words
`timescale 1ns/100ps
module thrdp_trig_lut (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic [3:0]  wr_idx,
    input  wire logic [31:0] wr_data,
    input  wire logic [3:0]  rd_idx,
    output logic      [31:0] rd_data,
    input  wire logic [5:0]  pattern,
    output logic      [7:0]  trig_type
);
    typedef struct packed {
        logic [15:0][31:0] words;
        logic [7:0]        type_out;
    } thrdp_lut_t;

    thrdp_lut_t s_q;
    thrdp_lut_t s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.words[wr_idx] = wr_data;
        end
        s_d.type_out = s_q.words[pattern[5:2]][pattern[1:0]*8 +: 8];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rd_data   = s_q.words[rd_idx];
    assign trig_type = s_q.type_out;
endmodule

// ---- hw/thrdp_host_regs.sv ----
// host register bank, window decode and ring-buffer dma write engine
//
// Behaviour
// - 512-byte register window, whole words only
// - 4 kbyte second window, programming engine
// - 1 MB read-only event data window
// - ready block pushed by dma into ring
// - id bits 15-14 read 10 when running
// - id bits 31-20 carry board type
// - transceiver bypass bit resets to one
// - bits 31-16 give buffered word count
// - interrupt id, level, enable with defaults
// - trigger delay and width (n+1) ticks
// - dma position read back block fields
// - block size writable, level, master size
// - event format bits add data words
// - bit 23 allows interrupts to processor
// - bit 24 releases one block, ORed 22
// - bit 25 auto reset on stuck frame
// - bit 26 gates data to dma
// - bits 30:28 = 101 select i2c engine
// - six inputs through 64-entry type table
`timescale 1ns/100ps
`include "thrdp_cfg.svh"
module thrdp_host_regs #(
    parameter logic [11:0] BOARD_TYPE = 12'h5A5, // arbitrary value
    parameter logic [3:0]  PCB_REV    = 4'h1
) (
    input  wire logic                clk,
    input  wire logic                sys_rst,
    input  wire thrdp_pkg::thrdp_req_t host_req,
    output thrdp_pkg::thrdp_rsp_t    host_rsp,
    input  wire logic                sup_running,
    input  wire logic [7:0]          blk_level,
    input  wire logic [7:0]          blk_master,
    input  wire logic                evt_valid,
    input  wire logic [31:0]         evt_data,
    output logic                     evt_ready,
    input  wire logic                block_ready,
    input  wire logic                eof_stuck,
    input  wire logic [1:0]          ring_size,
    output logic                     dma_wr,
    output logic [31:0]              dma_addr,
    output logic [31:0]              dma_data,
    output logic                     link_reset,
    output logic                     irq_out,
    output logic                     w1_i2c_sel,
    output logic                     w1_wr,
    output logic                     w1_rd,
    output logic [9:0]               w1_idx,
    output logic [31:0]              w1_wdata,
    input  wire logic [31:0]         w1_rdata,
    output logic                     xcvr_bypass,
    output logic [3:0]               evt_format,
    input  wire logic                trig1_in,
    input  wire logic                trig2_in,
    output logic                     trig1_out,
    output logic                     trig2_out,
    input  wire logic [5:0]          fp_inputs,
    output logic [7:0]               trig_type
);
    typedef struct packed {
        thrdp_pkg::thrdp_ctl_t    ctl;
        thrdp_pkg::thrdp_rsp_t    rsp;
        thrdp_pkg::thrdp_dma_st_t st;
        logic                     grant;
        logic [9:0]               beat;
        logic [19:0]              pos;
        logic [15:0]              level;
        logic [8:0]               eof_cnt;
        logic                     link_rst;
        logic                     dma_wr;
        logic [31:0]              dma_addr;
        logic [31:0]              dma_data;
        logic                     irq;
        logic                     w1_wr;
        logic                     w1_rd;
        logic [9:0]               w1_idx;
        logic [31:0]              w1_wdata;
        logic                     w1_pend;
    } thrdp_state_t;

    thrdp_state_t s_q;
    thrdp_state_t s_d;

    logic        lut_wr;
    logic [31:0] lut_rdata;
    logic [1:0]  t_raw;
    logic [7:0]  t_type;
    logic        t1_q;
    logic        t2_q;
    logic        accept;

    // word-aligned byte offset inside the register window; low two address bits ignored
    function automatic logic [8:0] reg_off(input logic [19:0] a);
        reg_off = {a[8:2], 2'b00};
    endfunction

    function automatic logic is_lut(input logic [19:0] a);
        is_lut = (reg_off(a) >= `THRDP_OFF_LUT_BASE);
    endfunction

    assign lut_wr = host_req.wr && host_req.win == 2'd0
                    && is_lut(host_req.addr);
    assign accept = s_q.st == thrdp_pkg::THRDP_SEND && evt_valid
                    && s_q.ctl.dma_en;

    always_comb begin
        s_d = s_q;
        s_d.rsp = '0;
        s_d.dma_wr = 1'b0;
        s_d.w1_wr = 1'b0;
        s_d.w1_rd = 1'b0;
        s_d.link_rst = 1'b0;
        s_d.irq = 1'b0;
        s_d.ctl.blk_dma = 1'b0;
        if (s_q.w1_pend && host_req.rd == 1'b0) begin
            s_d.w1_pend = 1'b0;
            s_d.rsp.valid = 1'b1;
            s_d.rsp.rdata = w1_rdata;
        end
        if (host_req.wr && host_req.win == 2'd0) begin
            case (reg_off(host_req.addr))
                `THRDP_OFF_BOARD_IDENTIFICATION: begin
                    s_d.ctl.crate_id = host_req.wdata[7:0];
                end
                `THRDP_OFF_XCVR: begin
                    s_d.ctl.xcvr_byp = host_req.wdata[0];
                end
                `THRDP_OFF_IRQ_SET: begin
                    s_d.ctl.irq_id  = host_req.wdata[7:0];
                    s_d.ctl.irq_lvl = host_req.wdata[10:8];
                    s_d.ctl.irq_en  = host_req.wdata[16];
                end
                `THRDP_OFF_TRG_DLY: begin
                    s_d.ctl.t1_dly = host_req.wdata[7:0];
                    s_d.ctl.t1_wid = host_req.wdata[15:8];
                    s_d.ctl.t2_dly = host_req.wdata[23:16];
                    s_d.ctl.t2_wid = host_req.wdata[31:24];
                end
                `THRDP_OFF_BLK_SIZE: begin
                    s_d.ctl.blk_wr = host_req.wdata[7:0];
                end
                `THRDP_OFF_EVT_FMT: begin
                    s_d.ctl.evt_fmt = host_req.wdata[3:0];
                end
                `THRDP_OFF_HOST_SET: begin
                    s_d.ctl.blk_upd  = host_req.wdata[`THRDP_BIT_BLK_UPD];
                    s_d.ctl.blk_dma  = host_req.wdata[`THRDP_BIT_BLK_DMA]
                                     | host_req.wdata[`THRDP_BIT_ONE_BLK];
                    s_d.ctl.cpu_irq  = host_req.wdata[`THRDP_BIT_IRQ_EN];
                    s_d.ctl.auto_rst = host_req.wdata[`THRDP_BIT_AUTO_RST];
                    s_d.ctl.dma_en   = host_req.wdata[`THRDP_BIT_DMA_EN];
                    s_d.ctl.w1_sel   = host_req.wdata[30:28];
                end
                default: begin
                end
            endcase
        end
        if (host_req.rd && host_req.win == 2'd0) begin
            s_d.rsp.valid = 1'b1;
            case (reg_off(host_req.addr))
                `THRDP_OFF_BOARD_IDENTIFICATION: begin
                    s_d.rsp.rdata = {BOARD_TYPE, PCB_REV,
                        sup_running ? `THRDP_RUN_CODE : 2'h0,
                        6'h00, s_q.ctl.crate_id};
                end
                `THRDP_OFF_XCVR: begin
                    s_d.rsp.rdata = {s_q.level, 15'h0000,
                                     s_q.ctl.xcvr_byp};
                end
                `THRDP_OFF_IRQ_SET: begin
                    s_d.rsp.rdata = {15'h0000, s_q.ctl.irq_en, 5'h00,
                                     s_q.ctl.irq_lvl, s_q.ctl.irq_id};
                end
                `THRDP_OFF_TRG_DLY: begin
                    s_d.rsp.rdata = {s_q.ctl.t2_wid, s_q.ctl.t2_dly,
                                     s_q.ctl.t1_wid, s_q.ctl.t1_dly};
                end
                `THRDP_OFF_DMA_POS: begin
                    s_d.rsp.rdata = {12'h000, s_q.pos[19:7],
                                     7'h00};
                end
                `THRDP_OFF_BLK_SIZE: begin
                    s_d.rsp.rdata = {blk_master, blk_level, 8'h00,
                                     s_q.ctl.blk_wr};
                end
                `THRDP_OFF_EVT_FMT: begin
                    s_d.rsp.rdata = {28'h0000000, s_q.ctl.evt_fmt};
                end
                `THRDP_OFF_HOST_SET: begin
                    s_d.rsp.rdata = {1'b0, s_q.ctl.w1_sel, 1'b0,
                        s_q.ctl.dma_en, s_q.ctl.auto_rst, 1'b0,
                        s_q.ctl.cpu_irq, 1'b0, s_q.ctl.blk_upd,
                        21'h000000};
                end
                default: begin
                    s_d.rsp.rdata = is_lut(host_req.addr) ? lut_rdata
                                                          : 32'h00000000;
                end
            endcase
        end
        // second window forwarded to the programming engine
        if (host_req.win == 2'd1) begin
            s_d.w1_wr    = host_req.wr;
            s_d.w1_rd    = host_req.rd;
            s_d.w1_idx   = host_req.addr[11:2];
            s_d.w1_wdata = host_req.wdata;
            s_d.w1_pend  = host_req.rd;
        end
        // third window: reads give the head event word, writes dropped
        if (host_req.rd && host_req.win == 2'd2) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.rdata = evt_valid ? evt_data : 32'h00000000;
        end
        if (host_req.rd && host_req.win == 2'd3) begin
            s_d.rsp.valid = 1'b1;
            s_d.rsp.rdata = 32'h00000000;
        end
        case (s_q.st)
            thrdp_pkg::THRDP_IDLE: begin
                if ((block_ready || s_q.ctl.blk_dma) && s_q.ctl.dma_en) begin
                    s_d.st = thrdp_pkg::THRDP_SEND;
                    s_d.beat = 10'h000;
                    s_d.level = 16'h0200;
                end
            end
            thrdp_pkg::THRDP_SEND: begin
                if (!s_q.ctl.dma_en) begin
                    s_d.st = thrdp_pkg::THRDP_IDLE;
                end else if (evt_valid) begin
                    s_d.dma_wr   = 1'b1;
                    s_d.dma_addr = {12'h000, s_q.pos};
                    s_d.dma_data = evt_data;
                    s_d.beat     = s_q.beat + 10'h001;
                    if (s_q.beat[0]) s_d.level = s_q.level - 16'h0001;
                    // wrap at the allocated ring size
                    case (ring_size)
                        2'd1: s_d.pos = {1'b0, s_q.pos[18:0] + 19'h00004};
                        2'd2: s_d.pos = s_q.pos + 20'h00004;
                        default: s_d.pos = {2'b00,
                                     s_q.pos[17:0] + 18'h00004};
                    endcase
                    if (s_q.beat == `THRDP_BLOCK_WORDS) begin
                        s_d.st  = thrdp_pkg::THRDP_IDLE;
                        s_d.irq = s_q.ctl.cpu_irq && s_q.ctl.irq_en;
                    end
                end
            end
            default: begin
                s_d.st = thrdp_pkg::THRDP_IDLE;
            end
        endcase
        // stuck end-of-frame watchdog
        if (eof_stuck && s_q.ctl.auto_rst) begin
            if (s_q.eof_cnt == `THRDP_EOF_LIMIT) begin
                s_d.link_rst = 1'b1;
                s_d.eof_cnt  = 9'h000;
            end else begin
                s_d.eof_cnt = s_q.eof_cnt + 9'h001;
            end
        end else begin
            s_d.eof_cnt = 9'h000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q <= '0;
            s_q.ctl.crate_id <= `THRDP_RST_CRATE_ID;
            s_q.ctl.xcvr_byp <= `THRDP_RST_XCVR_BYP;
            s_q.ctl.irq_id   <= `THRDP_RST_IRQ_ID;
            s_q.ctl.irq_lvl  <= `THRDP_RST_IRQ_LVL;
            s_q.ctl.t1_dly   <= `THRDP_RST_TRG_FIELD;
            s_q.ctl.t1_wid   <= `THRDP_RST_TRG_FIELD;
            s_q.ctl.t2_dly   <= `THRDP_RST_TRG_FIELD;
            s_q.ctl.t2_wid   <= `THRDP_RST_TRG_FIELD;
            s_q.ctl.blk_wr   <= `THRDP_RST_BLK_SIZE;
            s_q.ctl.evt_fmt  <= `THRDP_RST_EVT_FMT;
            s_q.st           <= thrdp_pkg::THRDP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    thrdp_trig_lut u_lut (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .wr_en     (lut_wr),
        .wr_idx    (host_req.addr[5:2]),
        .wr_data   (host_req.wdata),
        .rd_idx    (host_req.addr[5:2]),
        .rd_data   (lut_rdata),
        .pattern   (fp_inputs),
        .trig_type (t_type)
    );

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_shp
            thrdp_trig_shaper u_shp (
                .clk      (clk),
                .sys_rst  (sys_rst),
                .trig_in  (g == 0 ? trig1_in : trig2_in),
                .delay_n  (g == 0 ? s_q.ctl.t1_dly : s_q.ctl.t2_dly),
                .width_n  (g == 0 ? s_q.ctl.t1_wid : s_q.ctl.t2_wid),
                .trig_out (t_raw[g])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            t1_q <= 1'b0;
            t2_q <= 1'b0;
        end else begin
            t1_q <= t_raw[0];
            t2_q <= t_raw[1];
        end
    end

    assign host_rsp    = s_q.rsp;
    assign evt_ready   = accept;
    assign dma_wr      = s_q.dma_wr;
    assign dma_addr    = s_q.dma_addr;
    assign dma_data    = s_q.dma_data;
    assign link_reset  = s_q.link_rst;
    assign irq_out     = s_q.irq;
    assign w1_i2c_sel  = (s_q.ctl.w1_sel == `THRDP_I2C_SEL);
    assign w1_wr       = s_q.w1_wr;
    assign w1_rd       = s_q.w1_rd;
    assign w1_idx      = s_q.w1_idx;
    assign w1_wdata    = s_q.w1_wdata;
    assign xcvr_bypass = s_q.ctl.xcvr_byp;
    assign evt_format  = s_q.ctl.evt_fmt;
    assign trig1_out   = t1_q;
    assign trig2_out   = t2_q;
    assign trig_type   = t_type;
endmodule

// ---- tb/thrdp_monitor.sv ----
// concurrent checks on the host register bank ports
`timescale 1ns/100ps
module thrdp_monitor #(
    parameter logic [11:0] BOARD_TYPE = 12'h5A5,
    parameter logic [3:0]  PCB_REV    = 4'h1
) (
    input wire logic                  clk,
    input wire logic                  sys_rst,
    input wire thrdp_pkg::thrdp_req_t host_req,
    input wire thrdp_pkg::thrdp_rsp_t host_rsp,
    input wire logic                  sup_running,
    input wire logic                  evt_valid,
    input wire logic                  evt_ready,
    input wire logic                  eof_stuck,
    input wire logic                  dma_wr,
    input wire logic [31:0]           dma_addr,
    input wire logic                  link_reset,
    input wire logic                  w1_i2c_sel,
    input wire logic                  w1_rd,
    input wire logic                  xcvr_bypass,
    input wire logic [3:0]            evt_format
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [8:0] stuck_q;
    logic [8:0] stuck_d;
    // consecutive stuck cycles, saturating
    always_comb begin
        stuck_d = stuck_q;
        if (!eof_stuck)
            stuck_d = 9'h000;
        else if (stuck_q != 9'h1FF)
            stuck_d = stuck_q + 9'h001;
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            stuck_q <= 9'h000;
        else
            stuck_q <= stuck_d;
    end
    sequence s_hit(logic k, logic [8:0] a);
        k && host_req.win == 2'h0 && host_req.addr[8:0] == a;
    endsequence
    sequence s_take;
        evt_valid && evt_ready;
    endsequence
    AST_RSP_LAT: assert property (
        host_req.rd && host_req.win != 2'h1 |=> host_rsp.valid)
        else $error("read answer missing");
    AST_BOARD_TYPE: assert property (
        s_hit(host_req.rd, 9'h000) |=>
        host_rsp.rdata[31:16] == {BOARD_TYPE, PCB_REV})
        else $error("board type field wrong");
    AST_RUN_CODE: assert property (
        s_hit(host_req.rd, 9'h000) |=>
        host_rsp.rdata[15:8] == {$past(sup_running), 7'h00})
        else $error("run code field wrong");
    AST_POS_LOW: assert property (
        s_hit(host_req.rd, 9'h010) |=> host_rsp.rdata[6:0] == 7'h00)
        else $error("dma position low bits set");
    AST_W1_RD: assert property (
        host_req.rd && host_req.win == 2'h1 |=>
        w1_rd ##1 (!w1_rd && host_rsp.valid))
        else $error("second window read sequence wrong");
    AST_DMA_NEXT: assert property (
        s_take |=> dma_wr)
        else $error("accepted word not written");
    AST_DMA_ADDR: assert property (
        dma_wr ##1 dma_wr |-> dma_addr == $past(dma_addr) + 32'h4)
        else $error("dma address step wrong");
    AST_AUTO_RST: assert property (
        link_reset |-> stuck_q >= 9'h100)
        else $error("link reset too early");
    AST_BYP_RST: assert property (
        $fell(sys_rst) |-> xcvr_bypass && evt_format == 4'h3)
        else $error("reset values of bypass or format wrong");
    AST_I2C_SEL: assert property (
        s_hit(host_req.wr, 9'h01C) |=>
        w1_i2c_sel == ($past(host_req.wdata[30:28]) == 3'h5))
        else $error("second window engine select wrong");
endmodule
bind thrdp_host_regs thrdp_monitor #(.BOARD_TYPE(BOARD_TYPE),
    .PCB_REV(PCB_REV)) u_mon (.clk, .sys_rst, .host_req, .host_rsp,
    .sup_running, .evt_valid, .evt_ready, .eof_stuck, .dma_wr, .dma_addr,
    .link_reset, .w1_i2c_sel, .w1_rd, .xcvr_bypass, .evt_format);

// ---- tb/thrdp_ring_host.sv ----
// host side model: event word feed and dma ring memory check
`timescale 1ns/100ps
module thrdp_ring_host (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        slow,
    input  wire logic        evt_ready,
    input  wire logic        dma_wr,
    input  wire logic [31:0] dma_addr,
    input  wire logic [31:0] dma_data,
    output logic             evt_valid,
    output logic      [31:0] evt_data,
    output int               n_wr,
    output int               n_err
);
    logic [31:0] sent_q;
    logic [31:0] exp_q;
    logic        gap_q;
    assign evt_valid = !sys_rst && !gap_q;
    // idle data shows the inverted sent-word count, not the last word
    assign evt_data = evt_valid ? 32'hA500_0000 + sent_q : ~sent_q;
    always @(posedge clk) begin
        if (sys_rst) begin
            sent_q <= 32'h0;
            exp_q <= 32'h0;
            gap_q <= 1'b0;
            n_wr <= 0;
            n_err <= 0;
        end else begin
            if (evt_valid && evt_ready)
                sent_q <= sent_q + 32'h1;
            gap_q <= slow && evt_valid && evt_ready;
            if (dma_wr) begin
                n_wr <= n_wr + 1;
                if (dma_addr !== {exp_q[29:0], 2'b00} ||
                    dma_data !== 32'hA500_0000 + exp_q)
                    n_err <= n_err + 1;
                exp_q <= exp_q + 32'h1;
            end
        end
    end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the host register bank
`timescale 1ns/100ps
module tb_top;
    logic                  clk;
    logic                  sys_rst;
    thrdp_pkg::thrdp_req_t req;
    thrdp_pkg::thrdp_rsp_t rsp;
    logic [5:0]            fp;
    logic [7:0]            ttype;
    logic [1:0]            tin;
    logic [1:0]            tout;
    logic [31:0]           dadr;
    logic [31:0]           ddat;
    logic [31:0]           rdat;
    logic [31:0]           w1d;
    logic [3:0]            evf;
    logic                  eof, slow, ev, er, dwr, lrst, irq, i2c, byp;
    logic [31:0]           evd;
    int                    bad_count, n_tests, irqs, n_wr, n_err, i;
    logic [8:0]  ra [8] = '{9'h000, 9'h004, 9'h008, 9'h00C,
                            9'h010, 9'h014, 9'h018, 9'h01C};
    logic [31:0] rv [8] = '{32'h5A51_8000, 32'h1, 32'h5C8, 32'h0707_0707,
                            32'h0, 32'h3C12_0001, 32'h3, 32'h0};

    thrdp_host_regs u_dut (.clk(clk), .sys_rst(sys_rst), .host_req(req),
        .host_rsp(rsp), .sup_running(byp), .blk_level(8'h12),
        .blk_master(8'h3C), .evt_valid(ev), .evt_data(evd),
        .evt_ready(er), .block_ready(1'b0), .eof_stuck(eof),
        .ring_size(2'h1), .dma_wr(dwr), .dma_addr(dadr), .dma_data(ddat),
        .link_reset(lrst), .irq_out(irq), .w1_i2c_sel(i2c), .w1_wr(),
        .w1_rd(), .w1_idx(), .w1_wdata(), .w1_rdata(w1d),
        .xcvr_bypass(byp), .evt_format(evf), .trig1_in(tin[0]),
        .trig2_in(tin[1]), .trig1_out(tout[0]), .trig2_out(tout[1]),
        .fp_inputs(fp), .trig_type(ttype));
    thrdp_ring_host u_host (.clk(clk), .sys_rst(sys_rst), .slow(slow),
        .evt_ready(er), .dma_wr(dwr), .dma_addr(dadr), .dma_data(ddat),
        .evt_valid(ev), .evt_data(evd), .n_wr(n_wr), .n_err(n_err));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (irq === 1'b1)
            irqs++;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [1:0] win,
                       input logic [8:0] a, input logic [31:0] d);
        int n;
        @(negedge clk);
        req = '{w, !w, win, {11'h000, a}, d};
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b0;
        for (n = 0; n < 8 && !w && rsp.valid !== 1'b1; n++)
            @(negedge clk);
        rdat = rsp.rdata;
        if (n == 8) begin
            bad_count++;
            finish_test();
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        acc(1'b1, 2'h0, a, d);
    endtask
    task automatic rd(input logic [1:0] win, input logic [8:0] a,
                      input logic [31:0] e);
        acc(1'b0, win, a, 32'h0);
        chk(rdat, e);
    endtask
    task automatic pulse(input int k, input logic [31:0] e);
        int n;
        int j;
        n = 0;
        @(negedge clk);
        tin[k] = 1'b1;
        @(negedge clk);
        tin[k] = 1'b0;
        for (j = 0; j < 64; j++) begin
            @(negedge clk);
            n += (tout[k] === 1'b1);
        end
        chk(n, e);
    endtask
    task automatic stuck(output int n);
        eof = 1'b1;
        for (n = 0; n < 300 && lrst !== 1'b1; n++)
            @(negedge clk);
        eof = 1'b0;
    endtask

    initial begin
        sys_rst = 1'b1;
        req = '0;
        fp = 6'h00;
        tin = 2'b00;
        eof = 1'b0;
        slow = 1'b1;
        w1d = 32'h1234_5678;
        repeat (4) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        foreach (ra[k]) rd(2'h0, ra[k], rv[k]);
        wr(9'h000, 32'hFFFF_FFFF);
        rd(2'h0, 9'h000, 32'h5A51_80FF);
        wr(9'h008, 32'hFFFF_FFFF);
        rd(2'h0, 9'h008, 32'h0001_07FF);
        chk({31'h0, byp}, 32'h1);
        wr(9'h004, 32'h0);
        chk({31'h0, byp}, 32'h0);
        rd(2'h0, 9'h000, 32'h5A51_00FF);
        wr(9'h014, 32'hFFFF_FFAB);
        rd(2'h0, 9'h014, 32'h3C12_00AB);
        wr(9'h02C, 32'h2);
        wr(9'h024, 32'h10);
        rd(2'h0, 9'h02C, 32'h0);
        wr(9'h01C, 32'h5000_0000);
        chk({31'h0, i2c}, 32'h1);
        rd(2'h1, 9'h040, 32'h1234_5678);
        rd(2'h2, 9'h000, 32'hA500_0000);
        wr(9'h01C, 32'h4000_0000);
        chk({31'h0, i2c}, 32'h0);
        wr(9'h1C0, 32'h4433_2211);
        wr(9'h1FC, 32'hAB00_0000);
        fp = 6'h01;
        repeat (3) @(negedge clk);
        chk({24'h0, ttype}, 32'h22);
        fp = 6'h3F;
        repeat (3) @(negedge clk);
        chk({24'h0, ttype}, 32'hAB);
        wr(9'h00C, 32'h0503_0A01);
        pulse(0, 32'd11);
        pulse(1, 32'd6);
        wr(9'h018, 32'hE);
        chk({28'h0, evf}, 32'hE);
        wr(9'h01C, 32'h0580_0000);
        for (i = 0; i < 3000 && n_wr < 1024; i++)
            @(negedge clk) slow = i[7];
        repeat (8) @(negedge clk);
        chk(n_wr, 32'd1024);
        chk(n_err, 32'd0);
        chk(irqs, 32'd1);
        rd(2'h0, 9'h010, 32'h0000_1000);
        rd(2'h0, 9'h01C, 32'h0480_0000);
        wr(9'h01C, 32'h0100_0000);
        repeat (600) @(negedge clk);
        chk(n_wr, 32'd1024);
        wr(9'h01C, 32'h0);
        stuck(i);
        chk(i, 32'd300);
        wr(9'h01C, 32'h0200_0000);
        stuck(i);
        chk({31'h0, i >= 255 && i < 300}, 32'h1);
        finish_test();
    end
endmodule
